// ===== atap_defines.svh
// Timing constants for the two-channel disk-drive programmed-I/O host sequencer
// Assumes a 100 MHz core clock; times below are in ns unless named otherwise, ATAP_SYNC_LAT is in clock cycles
`ifndef ATAP_DEFINES_SVH
`define ATAP_DEFINES_SVH

`define ATAP_CLK_NS     10
`define ATAP_NS2CYC(ns) (((ns) + `ATAP_CLK_NS - 1) / `ATAP_CLK_NS)
`define ATAP_MODE_MAX   3'h4

// Per-mode tables, index 0 is mode 0
`define ATAP_T0_NS      '{600, 383, 240, 180, 120}
`define ATAP_T1_NS      '{70, 50, 30, 30, 25}
`define ATAP_T2REG_NS   '{290, 290, 290, 80, 70}
`define ATAP_T2DAT_NS   '{165, 125, 100, 80, 70}
`define ATAP_T2I_NS     '{0, 0, 0, 70, 25}
`define ATAP_T4_NS      '{30, 20, 15, 10, 10}
`define ATAP_T9_NS      '{20, 15, 10, 10, 10}

`define ATAP_TA_NS      35
`define ATAP_SYNC_LAT   3
`define ATAP_RST_US     25
`define ATAP_RST_CYC    ((`ATAP_RST_US * 1000) / `ATAP_CLK_NS)

`endif

// ===== atap_pkg.sv
// Types shared by the programmed-I/O host sequencer
// Assumes atap_defines.svh carries all numeric constants
package atap_pkg;

  typedef enum logic [2:0] {
    ATAP_IDLE   = 3'b000,
    ATAP_SETUP  = 3'b001,
    ATAP_ACTIVE = 3'b010,
    ATAP_WAIT   = 3'b011,
    ATAP_RECOV  = 3'b100
  } atap_state_e;

endpackage

// ===== atap_host_timing.sv
// Programmed-I/O host sequencer for two drive channels, modes 0 to 4
// Assumes one request at a time; address, chip selects and data pins are shared
// How it works
// - Each strobe-to-strobe cycle lasts at least the mode's minimum cycle time.
// - Cycle is active plus inactive time; cycle, active, recovery minimums all hold.
// - Short active plus recovery is padded by lengthening recovery to reach cycle time.
// - Register accesses hold strobe 290, 290, 290, 80, 70 ns by mode.
// - Data-port accesses hold strobe 165, 125, 100, 80, 70 ns by mode.
// - Strobes stay inactive 70 ns in mode 3, 25 ns in mode 4.
// - Address and chip selects are valid 70 to 25 ns before strobe.
// - Address and chip selects stay valid 20 to 10 ns after strobe.
// - Write data is set up before and held 30 to 10 ns after strobe.
// - Ready is first sampled 35 ns after strobe assertion.
// - Ready sampled low keeps the strobe asserted until ready returns.
// - Ready high at the sample point means no wait; cycle ends on timing.
// - Extended reads latch data at ready; others latch at strobe end.
// - Drive address is two active-low chip selects and three address bits.
`timescale 1ns/1ps
`include "atap_defines.svh"

module atap_host_timing
  import atap_pkg::*;
#(
  parameter int CNT_W   = 8,
  parameter int RST_CYC = `ATAP_RST_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [2:0]  chanMode0,
  input  wire logic [2:0]  chanMode1,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqChannel,
  input  wire logic        reqWrite,
  input  wire logic        reqDataPort,
  input  wire logic [1:0]  reqCsSel,
  input  wire logic [2:0]  reqAddr,
  input  wire logic [15:0] reqWdata,
  output logic             wrDone,
  output logic             rspValid,
  input  wire logic        rspReady,
  output logic [15:0]      rspData,
  output logic             rspChannel,
  output logic [1:0]       drive_chip_select_n,
  output logic [2:0]       drive_reg_addr,
  output logic [1:0]       drive_read_strobe_n,
  output logic [1:0]       drive_write_strobe_n,
  input  wire logic [1:0]  drive_ready_in,
  input  wire logic [15:0] drive_data_bus_in,
  output logic [15:0]      drive_data_bus_out,
  output logic             drive_data_bus_oe,
  output logic             drive_reset_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Mode tables and cycle counts

  localparam int T0 [5]  = `ATAP_T0_NS;
  localparam int T1 [5]  = `ATAP_T1_NS;
  localparam int T2R [5] = `ATAP_T2REG_NS;
  localparam int T2D [5] = `ATAP_T2DAT_NS;
  localparam int T2I [5] = `ATAP_T2I_NS;
  localparam int T4 [5]  = `ATAP_T4_NS;
  localparam int T9 [5]  = `ATAP_T9_NS;
  localparam logic [CNT_W-1:0] SAMPLE = CNT_W'(`ATAP_NS2CYC(`ATAP_TA_NS) + `ATAP_SYNC_LAT);
  localparam logic [CNT_W+1:0] ONE    = {{(CNT_W+1){1'b0}}, 1'b1};
  localparam int MAXEND = 64;

  function automatic logic [CNT_W-1:0] toCyc(input int ns);
    int c;
    c = `ATAP_NS2CYC(ns);
    toCyc = (c < 1) ? CNT_W'(1) : CNT_W'(c);
  endfunction

  wire logic [2:0]       modeRaw = reqChannel ? chanMode1 : chanMode0;
  wire logic [2:0]       mdSel   = (modeRaw > `ATAP_MODE_MAX) ? `ATAP_MODE_MAX : modeRaw;
  wire logic [CNT_W-1:0] setupN  = toCyc(T1[mdSel]);
  wire logic [CNT_W-1:0] actN    = toCyc(reqDataPort ? T2D[mdSel] : T2R[mdSel]);
  wire logic [CNT_W-1:0] recN    = toCyc(T2I[mdSel]);
  wire logic [CNT_W-1:0] cycN    = toCyc(T0[mdSel]);
  wire logic [CNT_W-1:0] holdN   = toCyc((T4[mdSel] > T9[mdSel]) ? T4[mdSel] : T9[mdSel]);

  ////////////////////////////////////////////////////////////////////////////////
  // Ready synchronisers, three stages with agreement filter

  logic [2:0] rdySync [2];
  logic [1:0] rdyLvl;

  for (genvar g = 0; g < 2; g++) begin : gSync
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        rdySync[g] <= 3'h7;
        rdyLvl[g]  <= 1'b1;
      end else begin
        rdySync[g] <= {rdySync[g][1:0], drive_ready_in[g]};
        if (rdySync[g][1] == rdySync[g][2]) begin
          rdyLvl[g] <= rdySync[g][2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  atap_state_e      state;
  atap_state_e      next_state;
  logic [CNT_W-1:0] cnt, actLen, setupC, actC, recC, cycC, holdC;
  logic             curCh, curWrite, extend;
  logic [15:0]      rstCnt;
  logic [15:0]      bufData [2];
  logic             bufCh [2];
  logic             wrPtr, rdPtr;
  logic [1:0]       bufCnt;

  wire logic rdyCur   = rdyLvl[curCh];
  wire logic rstBusy  = (rstCnt != 16'h0);
  wire logic accept   = reqValid && reqReady;
  wire logic needWait = (cnt == SAMPLE) ? !rdyCur : extend;
  wire logic actDone  = (cnt >= SAMPLE) && ({2'b0, cnt} + ONE >= {2'b0, actC});
  wire logic strobeOn = (next_state == ATAP_ACTIVE) || (next_state == ATAP_WAIT);
  wire logic rdEnd    = !curWrite && (next_state == ATAP_RECOV) && (state != ATAP_RECOV);
  wire logic pop      = rspValid && rspReady;
  wire logic [CNT_W+1:0] recLen = {2'b0, cnt} + ONE;
  wire logic [CNT_W+1:0] totLen = {2'b0, actLen} + recLen;
  wire logic recDone  = (recLen >= {2'b0, recC}) && (recLen >= {2'b0, holdC})
                        && (totLen >= {2'b0, cycC});

  assign reqReady = (state == ATAP_IDLE) && !rstBusy && (reqWrite || (bufCnt != 2'h2));
  assign rspValid = (bufCnt != 2'h0);
  assign rspData  = bufData[rdPtr];
  assign rspChannel = bufCh[rdPtr];

  always_comb begin
    next_state = state;
    case (state)
      ATAP_IDLE:   if (accept) next_state = ATAP_SETUP;
      ATAP_SETUP:  if ({2'b0, cnt} + ONE >= {2'b0, setupC}) next_state = ATAP_ACTIVE;
      ATAP_ACTIVE: if (actDone) next_state = needWait ? ATAP_WAIT : ATAP_RECOV;
      ATAP_WAIT:   if (rdyCur) next_state = ATAP_RECOV;
      ATAP_RECOV:  if (recDone) next_state = ATAP_IDLE;
      default:     next_state = ATAP_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ATAP_IDLE;
      cnt <= '0;
      actLen <= '0;
      extend <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= (next_state != state) ? '0 : cnt + 1'b1;
      actLen <= (state == ATAP_IDLE) ? '0
                : actLen + {{(CNT_W-1){1'b0}}, strobeOn && !(&actLen)};
      extend <= (state == ATAP_ACTIVE) && ((cnt == SAMPLE) ? !rdyCur : extend);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {setupC, actC, recC, cycC, holdC} <= '0;
      {curCh, curWrite} <= 2'b00;
    end else if (accept) begin
      {setupC, actC, recC, cycC, holdC} <= {setupN, actN, recN, cycN, holdN};
      {curCh, curWrite} <= {reqChannel, reqWrite};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drive_chip_select_n  <= 2'h3;
      drive_reg_addr       <= 3'h0;
      drive_data_bus_out   <= 16'h0;
      drive_data_bus_oe    <= 1'b0;
      drive_read_strobe_n  <= 2'h3;
      drive_write_strobe_n <= 2'h3;
      wrDone               <= 1'b0;
    end else begin
      if (accept) begin
        drive_chip_select_n <= ~reqCsSel;
        drive_reg_addr      <= reqAddr;
        drive_data_bus_out  <= reqWdata;
        drive_data_bus_oe   <= reqWrite;
      end else if (state == ATAP_RECOV && recDone) begin
        drive_chip_select_n <= 2'h3;
        drive_data_bus_oe   <= 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
        drive_read_strobe_n[i]  <= !(strobeOn && !curWrite && (curCh == i[0]));
        drive_write_strobe_n[i] <= !(strobeOn && curWrite && (curCh == i[0]));
      end
      wrDone <= curWrite && (state == ATAP_RECOV) && recDone;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rstCnt        <= 16'(RST_CYC);
      drive_reset_n <= 1'b0;
    end else begin
      rstCnt        <= rstBusy ? rstCnt - 1'b1 : rstCnt;
      drive_reset_n <= !rstBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry read buffer

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPtr  <= 1'b0;
      rdPtr  <= 1'b0;
      bufCnt <= 2'h0;
    end else begin
      wrPtr  <= wrPtr ^ rdEnd;
      rdPtr  <= rdPtr ^ pop;
      bufCnt <= bufCnt + {1'b0, rdEnd} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock) begin
    if (rdEnd) begin
      bufData[wrPtr] <= drive_data_bus_in;
      bufCh[wrPtr]   <= curCh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [CNT_W-1:0] lowRun, highRun, periodRun, addrRun, lastCyc, lastRec, lastHold;
  logic [4:0]       csAddrQ;
  logic             seenFall;
  wire logic strobeLow = !(&drive_read_strobe_n && &drive_write_strobe_n);
  wire logic addrMove  = ({drive_chip_select_n, drive_reg_addr} != csAddrQ);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {lowRun, highRun, periodRun, addrRun} <= '0;
      {lastCyc, lastRec, lastHold} <= '0;
      csAddrQ  <= 5'h18;
      seenFall <= 1'b0;
    end else begin
      lowRun    <= strobeLow ? lowRun + {{(CNT_W-1){1'b0}}, ~&lowRun} : '0;
      highRun   <= strobeLow ? '0 : highRun + {{(CNT_W-1){1'b0}}, ~&highRun};
      periodRun <= (strobeLow && lowRun == '0) ? CNT_W'(1)
                   : periodRun + {{(CNT_W-1){1'b0}}, ~&periodRun};
      addrRun   <= addrMove ? '0 : addrRun + {{(CNT_W-1){1'b0}}, ~&addrRun};
      csAddrQ   <= {drive_chip_select_n, drive_reg_addr};
      seenFall  <= seenFall || strobeLow;
      if (!strobeLow && lowRun != '0) begin
        {lastCyc, lastRec, lastHold} <= {cycC, recC, holdC};
      end
    end
  end

  sequence seqFall;
    strobeLow && (lowRun == '0) && seenFall;
  endsequence
  sequence seqSampleHigh;
    (state == ATAP_ACTIVE) && (cnt == SAMPLE) && rdyCur;
  endsequence

  chk_active_width: assert property (@(posedge clock) disable iff (!rst_n)
    (!strobeLow && lowRun != '0) |-> (lowRun >= actC))
    else $error("strobe active time below mode minimum");
  chk_cycle_time: assert property (@(posedge clock) disable iff (!rst_n)
    seqFall |-> (periodRun >= lastCyc))
    else $error("cycle time below mode minimum");
  chk_recovery_time: assert property (@(posedge clock) disable iff (!rst_n)
    seqFall |-> (highRun >= lastRec))
    else $error("recovery time below mode minimum");
  chk_addr_setup: assert property (@(posedge clock) disable iff (!rst_n)
    (strobeLow && lowRun == '0) |-> ({1'b0, addrRun} + 1'b1 >= {1'b0, setupC}) && !addrMove)
    else $error("address setup before strobe too short");
  chk_addr_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (addrMove && !strobeLow && seenFall) |-> (highRun >= lastHold))
    else $error("address hold after strobe too short");
  chk_wdata_hold: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(drive_data_bus_oe) |-> (highRun >= holdC) && $stable(drive_data_bus_out))
    else $error("write data released too early");
  chk_sample_point: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ATAP_ACTIVE && next_state == ATAP_WAIT) |-> (cnt == SAMPLE || extend) ##1 strobeLow)
    else $error("wait decided away from the sample point");
  chk_wait_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ATAP_WAIT && !rdyCur) |=> strobeLow)
    else $error("strobe released while ready low");
  chk_no_wait: assert property (@(posedge clock) disable iff (!rst_n)
    seqSampleHigh |-> ##[1:MAXEND] !strobeLow)
    else $error("cycle extended although ready was high");
  chk_read_latch: assert property (@(posedge clock) disable iff (!rst_n)
    rdEnd |=> (bufData[$past(wrPtr)] == $past(drive_data_bus_in)))
    else $error("read data not latched at cycle end");

endmodule

// ===== atap_drive_model.sv
// Behavioural drive on the far side of the programmed-I/O host sequencer
// Assumes a pulled-up ready line and data pins with no pull
`timescale 1ns/1ps

module atap_drive_model (
  input  wire logic [0:0]  clock,
  input  wire logic [1:0]  readStrobe_n,
  input  wire logic [1:0]  writeStrobe_n,
  input  wire logic [15:0] hostData,
  input  wire logic [7:0]  waitCyc,
  input  wire logic [15:0] readWord,
  output logic      [1:0]  readyOut,
  output logic      [15:0] driveData,
  output logic      [15:0] wrCapture
);
  logic [7:0] lowCnt = 8'h00;
  logic [1:0] prevStb = 2'h3;
  logic [1:0] stbN;
  logic       fall;
  assign stbN = readStrobe_n & writeStrobe_n;
  assign fall = (prevStb & ~stbN) != 2'h0;
  initial begin
    readyOut = 2'h3;
    driveData = 16'h0000;
    wrCapture = 16'h0000;
  end
  ////////////////////////////////////////
  always @(posedge clock) begin
    prevStb <= stbN;
    if (fall && waitCyc != 8'h00) begin
      readyOut <= stbN;
      lowCnt <= (waitCyc > 8'h7d ? 8'h7d : waitCyc) - 8'h01;
    end else if (lowCnt != 8'h00)
      lowCnt <= lowCnt - 8'h01;
    else
      readyOut <= 2'h3;
    if (readStrobe_n != 2'h3 && lowCnt == 8'h00 && !fall)
      driveData <= readWord;
    else
      driveData <= ~driveData;
    if (writeStrobe_n != 2'h3)
      wrCapture <= hostData;
  end
endmodule

// ===== tb_ata_pio_host_timing.sv
// Self-checking bench for the two-channel programmed-I/O host sequencer
// Assumes atap_drive_model on the drive pins; drive reset shortened to 20 cycles
`timescale 1ns/1ps

module tb_ata_pio_host_timing import atap_pkg::*;;
  typedef struct packed {
    logic        chan;
    logic [2:0]  mode;
    logic        wr;
    logic        dp;
    logic [1:0]  cs;
    logic [2:0]  addr;
    logic [15:0] word;
  } atap_row_s;
  localparam int RST = 20;
  int setT[5] = '{7, 5, 3, 3, 3};
  int regT[5] = '{29, 29, 29, 8, 8};
  int datT[5] = '{17, 13, 10, 8, 8};
  int recT[5] = '{1, 1, 1, 7, 3};
  int cycT[5] = '{60, 39, 24, 18, 12};
  int holdT[5] = '{3, 2, 2, 1, 1};
  atap_row_s rows[8] = '{
    '{1'h0, 3'h0, 1'h1, 1'h0, 2'h1, 3'h7, 16'h00a5},
    '{1'h1, 3'h1, 1'h0, 1'h0, 2'h2, 3'h1, 16'h00c3},
    '{1'h0, 3'h2, 1'h1, 1'h1, 2'h1, 3'h0, 16'h1234},
    '{1'h1, 3'h3, 1'h0, 1'h1, 2'h1, 3'h0, 16'hbeef},
    '{1'h0, 3'h4, 1'h1, 1'h0, 2'h2, 3'h6, 16'h005a},
    '{1'h1, 3'h4, 1'h1, 1'h1, 2'h1, 3'h0, 16'hffff},
    '{1'h0, 3'h3, 1'h0, 1'h0, 2'h2, 3'h2, 16'h0066},
    '{1'h1, 3'h0, 1'h0, 1'h1, 2'h1, 3'h0, 16'h8001}};
  logic        clock, rst_n, reqValid, reqReady, reqChannel, reqWrite, reqDataPort, rspReady;
  logic        wrDone, rspValid, rspChannel, drive_data_bus_oe, drive_reset_n;
  logic [2:0]  chanMode0, chanMode1, reqAddr, drive_reg_addr;
  logic [1:0]  reqCsSel, drive_chip_select_n, drive_read_strobe_n, drive_write_strobe_n;
  logic [1:0]  drive_ready_in, stbN;
  logic [15:0] reqWdata, rspData, drive_data_bus_in, drive_data_bus_out;
  logic [15:0] driveData, readWord, wrCapture;
  logic [7:0]  waitCyc;
  int          error_cnt = 0, num_checks = 0, s, a, r, n, ea;
  atap_row_s   w;
  assign drive_data_bus_in = drive_data_bus_oe ? drive_data_bus_out : driveData;
  assign stbN = drive_read_strobe_n & drive_write_strobe_n;
  atap_host_timing #(.RST_CYC(RST)) dut_u (
    .clock, .rst_n, .chanMode0, .chanMode1, .reqValid, .reqReady, .reqChannel, .reqWrite,
    .reqDataPort, .reqCsSel, .reqAddr, .reqWdata, .wrDone, .rspValid, .rspReady, .rspData,
    .rspChannel, .drive_chip_select_n, .drive_reg_addr, .drive_read_strobe_n,
    .drive_write_strobe_n, .drive_ready_in, .drive_data_bus_in, .drive_data_bus_out,
    .drive_data_bus_oe, .drive_reset_n);
  atap_drive_model drive_u (
    .clock, .readStrobe_n(drive_read_strobe_n), .writeStrobe_n(drive_write_strobe_n),
    .hostData(drive_data_bus_in), .waitCyc, .readWord, .readyOut(drive_ready_in),
    .driveData, .wrCapture);
  ////////////////////////////////////////
  function automatic int maxOf(int x, int y);
    return x > y ? x : y;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic inRange(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic pop(input logic ch, input logic [15:0] d);
    check({rspValid, rspChannel, rspData}, {1'b1, ch, d});
    rspReady = 1'b1;
    @(negedge clock);
    rspReady = 1'b0;
  endtask
  task automatic xfer(input atap_row_s q, input logic [7:0] wt);
    logic [1:0] sel;
    sel = 2'h3 ^ (2'h1 << q.chan);
    waitCyc = wt;
    readWord = q.word;
    chanMode0 = q.chan ? 3'h4 - q.mode : q.mode;
    chanMode1 = q.chan ? q.mode : 3'h4 - q.mode;
    {reqChannel, reqWrite, reqDataPort, reqCsSel, reqAddr, reqWdata} =
      {q.chan, q.wr, q.dp, q.cs, q.addr, q.word};
    reqValid = 1'b1;
    n = 0;
    #2;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge clock);
      #2;
      n++;
    end
    @(negedge clock);
    reqValid = 1'b0;
    while (drive_chip_select_n === 2'h3 && n < 200) begin
      @(negedge clock);
      n++;
    end
    s = 0;
    while (stbN[q.chan] && s < 200) begin
      @(negedge clock);
      s++;
    end
    check({drive_read_strobe_n, drive_write_strobe_n}, q.wr ? {2'h3, sel} : {sel, 2'h3});
    check({drive_chip_select_n, drive_reg_addr}, {~q.cs, q.addr});
    check(drive_data_bus_oe, q.wr);
    if (q.wr) check(drive_data_bus_out, q.word);
    a = 0;
    while (!stbN[q.chan] && a < 200) begin
      @(negedge clock);
      a++;
    end
    r = 0;
    while (drive_chip_select_n !== 2'h3 && r < 200) begin
      @(negedge clock);
      r++;
    end
    check({n < 200, s < 200, a < 200, r < 200}, 4'hf);
    check(wrDone, q.wr);
  endtask
  task automatic complete_run;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Whole run needs about 500 cycles
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    complete_run;
  end
  initial begin
    {rst_n, reqValid, reqChannel, reqWrite, reqDataPort, rspReady, reqCsSel, reqAddr} = '0;
    {chanMode0, chanMode1, reqWdata, readWord, waitCyc} = '0;
    repeat (3) @(negedge clock);
    check({drive_read_strobe_n, drive_write_strobe_n, drive_chip_select_n,
           drive_data_bus_oe, drive_reset_n, reqReady}, 9'h1f8);
    rst_n = 1'b1;
    n = 0;
    while (drive_reset_n !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    inRange(n, RST, RST + 1);
    for (int i = 0; i < 8; i++) begin
      w = rows[i];
      xfer(w, 8'h00);
      ea = w.dp ? datT[w.mode] : regT[w.mode];
      check(s, setT[w.mode]);
      check(a, ea);
      check(r, maxOf(maxOf(cycT[w.mode] - ea, recT[w.mode]), holdT[w.mode]));
      if (!w.wr) pop(w.chan, w.word);
    end
    xfer(atap_row_s'{1'h1, 3'h4, 1'h0, 1'h1, 2'h2, 3'h0, 16'h0f0f}, 8'h01);
    check(a, 8);
    pop(1'b1, 16'h0f0f);
    xfer(atap_row_s'{1'h0, 3'h4, 1'h0, 1'h0, 2'h1, 3'h3, 16'h5aa5}, 8'h0c);
    inRange(a, 12, 20);
    pop(1'b0, 16'h5aa5);
    xfer(atap_row_s'{1'h1, 3'h3, 1'h1, 1'h1, 2'h1, 3'h0, 16'hc33c}, 8'h14);
    inRange(a, 20, 28);
    check(wrCapture, 16'hc33c);
    xfer(atap_row_s'{1'h0, 3'h7, 1'h1, 1'h1, 2'h1, 3'h0, 16'h7e7e}, 8'h00);
    check(s, setT[4]);
    check(a, datT[4]);
    check(r, maxOf(cycT[4] - datT[4], recT[4]));
    xfer(rows[1], 8'h00);
    xfer(rows[3], 8'h00);
    #2;
    check(reqReady, 1'b0);
    @(negedge clock);
    reqWrite = 1'b1;
    #2;
    check(reqReady, 1'b1);
    @(negedge clock);
    pop(1'b1, rows[1].word);
    @(negedge clock);
    pop(1'b1, rows[3].word);
    check(rspValid, 1'b0);
    complete_run;
  end
endmodule
